// ---- sac_top.sv ----
// register front end and conversion sequencer of the sar converter
// What this block does
// R1: channel codes pick pins, battery, temperature
// R2: divider code selects core clock divide ratio
// R3: one result per sixteen converter clocks
// R4: gain field drives amplifier gain select
// R5: offset test on channel 1 inverts all twelve result bits
// R6: config bit selects differential input
// R7: config bit enables input buffer
// R8: config bit zero powers converter
// R9: done status synchronised, one when finished
// R10: charge status bit mirrors capacitor charging
// R11: busy status bit mirrors touch sequence
// R12: writable bit powers touch module
// R13: start bit begins conversion, self clears
// R14: temperature control bit powers sensor
// R15: software leaves sensor trim at reset
// R16: data register holds latest twelve bits
// R17: end sets flag, control write clears
// R18: four sample, twelve convert, one gap
// R19: differential pairs channel 0/2, 1/3
// R20: start without power clears, no flag
`default_nettype none
module sac_top (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic adc_eoc_async_i,
  input wire logic [11:0] adc_result_i,
  input wire logic touch_charge_i,
  input wire logic touch_busy_i,
  output logic adc_clk_o,
  output logic adc_sample_o,
  output logic [3:0] adc_pos_sel_o,
  output logic [3:0] adc_neg_sel_o,
  output logic vbat_sel_o,
  output logic temp_sel_o,
  output logic [1:0] adc_gain_o,
  output logic adc_diff_o,
  output logic adc_buf_o,
  output logic adc_power_o,
  output logic touch_power_o,
  output logic temp_power_o,
  output logic [2:0] temp_trim_o
);
  import sac_pkg::*;
  // every check below runs on the core clock and sleeps in reset
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // divisor for a divider select code
  function automatic logic [3:0] div_of(input logic [1:0] sel);
    case (sel)
      2'b00: div_of = DIV_00;
      2'b01: div_of = DIV_01;
      2'b10: div_of = DIV_10;
      default: div_of = DIV_11;
    endcase
  endfunction

  // bus front end state
  logic wr_pend_reg, wr_pend_next; // write data phase due
  logic [2:0] wr_idx_reg, wr_idx_next; // index of pending write
  logic [31:0] rdata_reg, rdata_next;
  logic ready_reg;
  // software visible registers
  logic [3:0] chan_reg, chan_next;
  logic [7:0] cfg_reg, cfg_next;
  logic tpwr_reg, tpwr_next; // touch power
  logic start_reg, start_next;
  logic [7:0] temp_reg, temp_next;
  logic [11:0] result_reg, result_next;
  logic [3:0] data_rsv_reg, data_rsv_next; // writable spare bits
  logic flag_reg, flag_next;
  logic [6:0] flag_rsv_reg, flag_rsv_next;
  // sequencer
  sac_state_t state_reg, state_next;
  logic [3:0] div_cnt_reg, div_cnt_next;
  logic aclk_reg, aclk_next;
  logic [4:0] cnt_reg, cnt_next;
  logic tick; // one core cycle per converter clock
  logic end_evt; // conversion finished this cycle
  logic abort_evt; // start dropped without result
  // three-stage synchronisers: eoc, charge, busy
  logic [2:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  // decoded strobes
  logic addr_ok, wr_conv, wr_cfg;
  // analog-facing flops
  logic [3:0] pos_next, neg_next;
  logic vbat_next, temps_next;
  logic [3:0] pos_reg, neg_reg;
  logic vbat_reg, temps_reg, samp_reg;

  // bus: address phase taken when hsel, an active htrans and hready are all high
  always_comb begin
    addr_ok = hsel_i && htrans_i[1] && hready_i;
    wr_pend_next = addr_ok && hwrite_i;
    wr_idx_next = haddr_i[4:2];
    rdata_next = 32'h0000_0000; // unmapped reads as zero
    if (addr_ok && !hwrite_i) begin
      case (haddr_i[4:2])
        IDX_CHAN: rdata_next[3:0] = chan_reg;
        IDX_CFG: rdata_next[7:0] = cfg_reg;
        IDX_CONV: begin
          rdata_next[CONV_DONE] = filt_reg[0]; // R9
          rdata_next[CONV_CHG] = filt_reg[1]; // R10
          rdata_next[CONV_BUSY] = filt_reg[2]; // R11
          rdata_next[CONV_TPWR] = tpwr_reg;
          rdata_next[CONV_START] = start_reg; // R13
        end
        IDX_TEMP: rdata_next[7:0] = temp_reg;
        IDX_DATA: rdata_next[15:0] = {data_rsv_reg, result_reg}; // R16
        IDX_FLAG: rdata_next[7:0] = {flag_reg, flag_rsv_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // bus: zero wait states, always okay
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 3'h0;
      rdata_reg <= 32'h0000_0000;
      ready_reg <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg <= wr_idx_next;
      rdata_reg <= rdata_next;
      ready_reg <= 1'b1;
    end
  end

  // synchronisers: a change counts once stages two and three agree
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      s3_reg <= 3'h0;
      filt_reg <= 3'h0;
    end else begin
      s1_reg <= {touch_busy_i, touch_charge_i, adc_eoc_async_i};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  // converter clock divider, free running off the core clock
  always_comb begin
    tick = div_cnt_reg >= div_of(cfg_reg[CFG_DIV+:2]) - 4'h1; // R2
    div_cnt_next = tick ? 4'h0 : div_cnt_reg + 4'h1;
    // high for the first half of each period
    aclk_next = div_cnt_next < (div_of(cfg_reg[CFG_DIV+:2]) >> 1);
  end

  // sequencer and register writes share one next-state process,
  // since the start bit and flag have both hardware and software writers
  always_comb begin
    wr_conv = wr_pend_reg && wr_idx_reg == IDX_CONV;
    wr_cfg = wr_pend_reg && wr_idx_reg == IDX_CFG;
    state_next = state_reg;
    cnt_next = cnt_reg;
    end_evt = 1'b0;
    abort_evt = 1'b0;
    chan_next = chan_reg;
    cfg_next = cfg_reg;
    tpwr_next = tpwr_reg;
    start_next = start_reg;
    temp_next = temp_reg;
    result_next = result_reg;
    data_rsv_next = data_rsv_reg;
    flag_next = flag_reg;
    flag_rsv_next = flag_rsv_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_reg && !cfg_reg[CFG_PWR]) begin
          start_next = 1'b0; // R20
          abort_evt = 1'b1;
        end else if (start_reg && tick) begin
          state_next = ST_SAMPLE; // R13
          cnt_next = 5'h00;
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == SAMPLE_CLKS - 5'h01) begin
            state_next = ST_CONVERT; // R18
            cnt_next = 5'h00;
          end
        end
      end
      ST_CONVERT: begin
        if (tick) begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == CONVERT_CLKS - 5'h01) begin
            end_evt = 1'b1; // R3 R18
            state_next = ST_GAP;
            start_next = 1'b0; // R13
            flag_next = 1'b1; // R17
            // test mode only on the one channel that supports it
            if (cfg_reg[CFG_OFS] && chan_reg == CH_OFS_TEST) begin
              result_next = ~adc_result_i; // R5
            end else begin
              result_next = adc_result_i; // R16
            end
          end
        end
      end
      ST_GAP: begin
        // one idle interval keeps back-to-back runs apart
        if (tick) begin
          state_next = ST_IDLE; // R18
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // power loss or a software stop cancels a running conversion
    if ((state_reg == ST_SAMPLE || state_reg == ST_CONVERT) &&
        (!cfg_reg[CFG_PWR] || !start_reg)) begin
      state_next = ST_IDLE;
      start_next = 1'b0;
      abort_evt = 1'b1;
    end
    if (wr_pend_reg) begin
      case (wr_idx_reg)
        IDX_CHAN: chan_next = hwdata_i[3:0];
        IDX_CFG: cfg_next = hwdata_i[7:0];
        IDX_CONV: begin
          tpwr_next = hwdata_i[CONV_TPWR]; // R12
          start_next = hwdata_i[CONV_START]; // R13
          flag_next = end_evt; // R17
        end
        IDX_TEMP: temp_next = hwdata_i[7:0]; // R14
        IDX_DATA: data_rsv_next = hwdata_i[15:12];
        IDX_FLAG: flag_rsv_next = hwdata_i[6:0];
        default: chan_next = chan_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 5'h00;
      div_cnt_reg <= 4'h0;
      aclk_reg <= 1'b0;
      chan_reg <= RST_CHAN;
      cfg_reg <= RST_CFG;
      tpwr_reg <= 1'b0;
      start_reg <= 1'b0;
      temp_reg <= RST_TEMP;
      result_reg <= 12'h000;
      data_rsv_reg <= 4'h0;
      flag_reg <= 1'b0;
      flag_rsv_reg <= 7'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      div_cnt_reg <= div_cnt_next;
      aclk_reg <= aclk_next;
      chan_reg <= chan_next;
      cfg_reg <= cfg_next;
      tpwr_reg <= tpwr_next;
      start_reg <= start_next;
      temp_reg <= temp_next;
      result_reg <= result_next;
      data_rsv_reg <= data_rsv_next;
      flag_reg <= flag_next;
      flag_rsv_reg <= flag_rsv_next;
    end
  end

  // input routing toward the analog mux
  always_comb begin
    pos_next = chan_reg; // R1
    vbat_next = chan_reg == CH_VBAT; // R1
    temps_next = chan_reg == CH_TEMP; // R1
    neg_next = 4'h0;
    if (cfg_reg[CFG_DIFF]) begin
      // only channels 0 and 1 have a negative partner
      if (chan_reg == 4'h0) begin
        neg_next = DIFF_NEG_CH0; // R19
      end else if (chan_reg == 4'h1) begin
        neg_next = DIFF_NEG_CH1; // R19
      end
    end
    if (chan_reg > CH_LAST_EXT) begin
      pos_next = 4'h0; // internal source, no pin
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_reg <= 4'h0;
      neg_reg <= 4'h0;
      vbat_reg <= 1'b0;
      temps_reg <= 1'b0;
      samp_reg <= 1'b0;
    end else begin
      pos_reg <= pos_next;
      neg_reg <= neg_next;
      vbat_reg <= vbat_next;
      temps_reg <= temps_next;
      samp_reg <= state_next == ST_SAMPLE;
    end
  end

  assign hrdata_o = rdata_reg;
  assign hreadyout_o = ready_reg;
  assign hresp_o = 1'b0;
  assign adc_clk_o = aclk_reg;
  assign adc_sample_o = samp_reg;
  assign adc_pos_sel_o = pos_reg;
  assign adc_neg_sel_o = neg_reg;
  assign vbat_sel_o = vbat_reg;
  assign temp_sel_o = temps_reg;
  assign adc_gain_o = cfg_reg[CFG_GAIN+:2]; // R4
  assign adc_diff_o = cfg_reg[CFG_DIFF]; // R6
  assign adc_buf_o = cfg_reg[CFG_BUF]; // R7
  assign adc_power_o = cfg_reg[CFG_PWR]; // R8
  assign touch_power_o = tpwr_reg; // R12
  assign temp_power_o = temp_reg[TEMP_PWR]; // R14
  assign temp_trim_o = temp_reg[2:0]; // R15

  // helper: converter clocks spent since leaving idle
  logic [4:0] run_ticks_reg;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_ticks_reg <= 5'h00;
    end else if (state_reg == ST_IDLE) begin
      run_ticks_reg <= 5'h00;
    end else if (tick && state_reg != ST_GAP) begin
      run_ticks_reg <= run_ticks_reg + 5'h01;
    end
  end

  property p_run_len;
    end_evt |-> run_ticks_reg == 5'h0F;
  endproperty
  a_run_len: assert property (p_run_len) else $error("run not 16 clocks"); // R18

  // the window must see no config write, or the divisor changes under it
  property p_div6;
    tick && cfg_reg[CFG_DIV+:2] == 2'b10 && !wr_cfg ##1 (!wr_cfg)[*5]
      |=> tick && !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3) &&
      !$past(tick, 4) && !$past(tick, 5);
  endproperty
  a_div6: assert property (p_div6) else $error("divide by 6 wrong"); // R2

  property p_flag_set;
    end_evt |=> flag_reg && !start_reg;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("end lost"); // R17

  property p_flag_clr;
    wr_conv && !end_evt |=> !flag_reg;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared"); // R17

  property p_nopwr;
    state_reg == ST_IDLE && start_reg && !cfg_reg[CFG_PWR] && !wr_pend_reg
      |=> !start_reg && $stable(flag_reg);
  endproperty
  a_nopwr: assert property (p_nopwr) else $error("unpowered start"); // R20

  property p_ofs;
    end_evt && cfg_reg[CFG_OFS] && chan_reg == CH_OFS_TEST
      |=> result_reg == ~$past(adc_result_i);
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset test result"); // R5

  property p_sync;
    $changed(filt_reg[0]) |-> $past(s2_reg[0]) == $past(s3_reg[0]);
  endproperty
  a_sync: assert property (p_sync) else $error("done status glitch"); // R9

  property p_diff;
    cfg_reg[CFG_DIFF] && chan_reg == 4'h1 |=> adc_neg_sel_o == DIFF_NEG_CH1;
  endproperty
  a_diff: assert property (p_diff) else $error("diff pair wrong"); // R19

  property p_temp_sel;
    chan_reg == CH_TEMP |=> temp_sel_o && !vbat_sel_o;
  endproperty
  a_temp_sel: assert property (p_temp_sel) else $error("temp route"); // R1

  c_end: cover property (end_evt);
  c_abort: cover property (abort_evt && cfg_reg[CFG_PWR]);
  c_back: cover property (end_evt ##[1:200] state_reg == ST_SAMPLE);
endmodule
`default_nettype wire

// ---- sac_pkg.sv ----
// package for the sar converter control block
`default_nettype none
package sac_pkg;
  // printed register offsets (not all word aligned, so used as indices)
  localparam logic [31:0] OFF_BASE = 32'h4000_1058;
  localparam logic [31:0] OFF_CHAN = 32'h4000_1058;
  localparam logic [31:0] OFF_CFG = 32'h4000_1059;
  localparam logic [31:0] OFF_CONV = 32'h4000_105A;
  localparam logic [31:0] OFF_TEMP = 32'h4000_105B;
  localparam logic [31:0] OFF_DATA = 32'h4000_105C;
  localparam logic [31:0] OFF_FLAG = 32'h4000_105E;
  // word index on the bus: byte address is four times the index
  localparam logic [2:0] IDX_CHAN = 3'(OFF_CHAN - OFF_BASE);
  localparam logic [2:0] IDX_CFG = 3'(OFF_CFG - OFF_BASE);
  localparam logic [2:0] IDX_CONV = 3'(OFF_CONV - OFF_BASE);
  localparam logic [2:0] IDX_TEMP = 3'(OFF_TEMP - OFF_BASE);
  localparam logic [2:0] IDX_DATA = 3'(OFF_DATA - OFF_BASE);
  localparam logic [2:0] IDX_FLAG = 3'(OFF_FLAG - OFF_BASE);
  // reset values
  localparam logic [3:0] RST_CHAN = 4'hF;
  localparam logic [7:0] RST_CFG = 8'hA0;
  localparam logic [7:0] RST_TEMP = 8'h04;
  // field positions
  localparam int CFG_DIV = 6;
  localparam int CFG_GAIN = 4;
  localparam int CFG_OFS = 3;
  localparam int CFG_DIFF = 2;
  localparam int CFG_BUF = 1;
  localparam int CFG_PWR = 0;
  localparam int CONV_DONE = 7;
  localparam int CONV_CHG = 5;
  localparam int CONV_BUSY = 4;
  localparam int CONV_TPWR = 3;
  localparam int CONV_START = 0;
  localparam int TEMP_PWR = 7;
  localparam int FLAG_EOC = 7;
  // clock divisors per divider select code
  localparam logic [3:0] DIV_00 = 4'hA;
  localparam logic [3:0] DIV_01 = 4'hC;
  localparam logic [3:0] DIV_10 = 4'h6;
  localparam logic [3:0] DIV_11 = 4'h8;
  // conversion timing in converter clocks
  localparam logic [4:0] SAMPLE_CLKS = 5'h04;
  localparam logic [4:0] CONVERT_CLKS = 5'h0C;
  // channel codes
  localparam logic [3:0] CH_LAST_EXT = 4'hD;
  localparam logic [3:0] CH_VBAT = 4'hE;
  localparam logic [3:0] CH_TEMP = 4'hF;
  localparam logic [3:0] CH_OFS_TEST = 4'h1;
  localparam logic [3:0] DIFF_NEG_CH0 = 4'h2;
  localparam logic [3:0] DIFF_NEG_CH1 = 4'h3;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_GAP = 4'b1000
  } sac_state_t;
endpackage
`default_nettype wire

// ---- sac_top_bench.sv ----
// self-checking bench for the sar converter control block
`default_nettype none
module sac_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sac_pkg::*;
  logic core_clk = 1'b0; // 250 MHz core clock
  logic rst = 1'b1; // async reset, high
  logic hsel = 1'b0; // bus request signals
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic eoc = 1'b0; // async status lines
  logic chg = 1'b0;
  logic tbsy = 1'b0;
  logic [11:0] res = 12'h000; // raw result from the analog side
  logic [31:0] hrdata;
  logic hready, hresp, aclk, samp, vbs, tps, adiff, abuf, apwr, tpwr, tspwr;
  logic [3:0] pos, neg;
  logic [1:0] gain;
  logic [2:0] trim;
  logic [31:0] rd; // data of the last read
  int miscompares = 0;
  int n_compared = 0;
  int mdl [8] = '{32'hF, 32'hA0, 0, 32'h4, 0, 0, 0, 0}; // register model
  int flag = 0; // model of the done flag
  int lastres = 0; // model of the latched result
  localparam int DIVS [4] = '{10, 12, 6, 8};

  sac_top dut_u (
    .core_clk_i(core_clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .adc_eoc_async_i(eoc), .adc_result_i(res), .touch_charge_i(chg),
    .touch_busy_i(tbsy), .adc_clk_o(aclk), .adc_sample_o(samp),
    .adc_pos_sel_o(pos), .adc_neg_sel_o(neg), .vbat_sel_o(vbs), .temp_sel_o(tps),
    .adc_gain_o(gain), .adc_diff_o(adiff), .adc_buf_o(abuf), .adc_power_o(apwr),
    .touch_power_o(tpwr), .temp_power_o(tspwr), .temp_trim_o(trim)
  );

  // free running clock, 4 ns period
  always #2 core_clk = ~core_clk;

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // verdict, the only exit
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // wait for hready at a rising edge, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge core_clk);
    while (hready !== 1'b1 && n < 50) begin
      n++;
      @(posedge core_clk);
    end
    if (n >= 50) miscompares++;
  endtask

  // one single ahb transfer; byte address is four times the index
  task automatic bus(input logic [2:0] idx, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {27'h0, idx, 2'h0};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  // expected read value from the model
  function automatic int exp_rd(int i);
    case (i)
      0: return mdl[0] & 32'hF;
      1, 3: return mdl[i] & 32'hFF;
      2: return (int'(eoc) << 7) | (int'(chg) << 5) | (int'(tbsy) << 4) | (mdl[2] & 9);
      4: return (mdl[4] & 32'hF000) | lastres;
      6: return (flag << 7) | (mdl[6] & 32'h7F);
      default: return 0; // unmapped words read zero
    endcase
  endfunction

  // write through the bus and keep the model in step
  task automatic wr(input int i, input int d);
    bus(i[2:0], 1'b1, d);
    if (i == 4) mdl[4] = d & 32'hF000;
    else if (i != 5 && i != 7) mdl[i] = d;
    if (i == 2) flag = 0; // any control write clears the flag
  endtask

  task automatic rchk(input int i);
    bus(i[2:0], 1'b0, 32'h0);
    check(rd, exp_rd(i));
  endtask

  // count edges until converter clock (0) or sample (1) reaches lvl
  task automatic wt(input int sel, input logic lvl, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while ((sel == 1 ? samp : aclk) !== lvl && n < 1000);
    if (n >= 1000) miscompares++;
  endtask

  // one full conversion; ratio, sample length, end effects
  task automatic conv(input int dv, input int c, input int ofs);
    int a, b, t0;
    wr(1, (dv << 6) | (ofs << 3) | 32'h23); // powered, buffer on, unity gain
    wr(0, c);
    wt(0, 0, a);
    wt(0, 1, a);
    wt(0, 0, a);
    wt(0, 1, b);
    check(a + b, DIVS[dv]);
    res <= 12'($urandom);
    wr(2, 1);
    t0 = $time;
    wt(1, 1, a);
    wt(1, 0, a);
    check(a, 4 * DIVS[dv]);
    a = 0;
    // poll the start bit; it must self clear
    do begin
      bus(3'h2, 1'b0, 32'h0);
      a++;
    end while (rd[0] !== 1'b0 && a < 200);
    b = ($time - t0) / 4;
    check(b >= 16 * DIVS[dv] && b <= 18 * DIVS[dv] + 12, 1);
    mdl[2] = mdl[2] & 8;
    flag = 1;
    lastres = (ofs != 0 && c == 1) ? (~res & 32'hFFF) : res;
    rchk(6);
    rchk(4);
    rchk(2);
    wr(2, mdl[2]);
    rchk(6);
  endtask

  // hang guard, well past the expected run time
  initial begin
    #200000;
    miscompares++;
    test_done();
  end

  // main sequence
  initial begin
    int v, c;
    void'($urandom(32'h8B432BB5));
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    // reset state of outputs and registers
    check({tps, gain, trim, hresp}, 7'b1_10_100_0);
    for (int i = 0; i < 8; i++) rchk(i);
    $display("test reset done");
    // every channel code, single ended then differential
    for (int k = 0; k < 32; k++) begin
      c = k % 16;
      if (k == 0 || k == 16) wr(1, k == 16 ? 32'h04 : 32'h00);
      wr(0, c);
      repeat (2) @(posedge core_clk);
      check(pos, c <= 13 ? c : 0);
      check({vbs, tps}, {c == 14, c == 15});
      check(neg, k == 16 ? 2 : (k == 17 ? 3 : 0));
      rchk(0);
    end
    $display("test channels done");
    // random configuration values, offset test held off
    repeat (8) begin
      v = $urandom & 32'hF7;
      wr(1, v);
      @(posedge core_clk);
      check({gain, adiff, abuf, apwr}, {v[5:4], v[2:0]});
      rchk(1);
    end
    $display("test config done");
    // a conversion for every divider code, offset test on and off
    conv(0, 1, 1);
    conv(1, 1, 0);
    conv(2, 5, 1);
    conv(3, 14, 0);
    wr(4, 32'hFFFF_A5A5);
    rchk(4);
    $display("test conversions done");
    // start while powered down: clears, no flag
    wr(1, 32'hA0);
    wr(2, 1);
    @(posedge core_clk);
    mdl[2] = 0;
    rchk(2);
    rchk(6);
    // abort mid run by clearing start: no flag
    wr(1, 32'h23);
    wr(2, 1);
    repeat (20) @(posedge core_clk);
    wr(2, 0);
    repeat (300) @(posedge core_clk);
    rchk(6);
    $display("test refusals done");
    // status lines through the synchroniser
    repeat (8) begin
      v = $urandom;
      eoc <= v[0];
      chg <= v[1];
      tbsy <= v[2];
      repeat (6) @(posedge core_clk);
      rchk(2);
    end
    // touch power, temperature power, trim kept at 100b
    wr(2, 8);
    @(posedge core_clk);
    check(tpwr, 1);
    v = ($urandom & 32'hF8) | 4;
    wr(3, v);
    @(posedge core_clk);
    check({tspwr, trim}, {v[7], 3'h4});
    rchk(3);
    rchk(2);
    // unmapped words and writable reserved flag bits
    wr(5, 32'hFF);
    wr(7, 32'hFF);
    wr(6, 32'h7F);
    rchk(5);
    rchk(7);
    rchk(6);
    $display("test status done");
    test_done();
  end
endmodule
`default_nettype wire
